/* dsw_pkg.sv */
// Constants and state type for the data space decoder and program counter block.
// Assumes an 8-bit core data bus and a 12-bit program memory address.
package dsw_pkg;
  localparam logic [7:0] BANK_HI = 8'h3F;
  localparam logic [7:0] WIN_LO = 8'h40;
  localparam logic [7:0] WIN_HI = 8'h7F;
  localparam logic [7:0] IDX_X_ADDR = 8'h80;
  localparam logic [7:0] IDX_Y_ADDR = 8'h81;
  localparam logic [7:0] SD_V_ADDR = 8'h82;
  localparam logic [7:0] SD_W_ADDR = 8'h83;
  localparam logic [7:0] RAM_LO = 8'h84;
  localparam logic [7:0] RAM_HI = 8'hBF;
  localparam logic [7:0] WIN_BASE_ADDR = 8'hC9;
  localparam logic [7:0] BANK_SEL_ADDR = 8'hE8;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 6;
  localparam int RAM_BYTES = 60;
  localparam int PAGE_BYTES = 64;
  localparam int WIN_POS_W = 6;
  localparam int RAM_PAGE2_BIT = 4;
  localparam int EEP1_BIT = 1;
  localparam int EEP0_BIT = 0;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [2:0] SP_LAST = 3'h5;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  localparam logic [7:0] PROTECTED_READ = 8'hFF;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
    logic [2:0] sp;
    logic [WIN_POS_W-1:0] win_pos;
    logic ram_page2_select;
    logic eeprom_page1_select;
    logic eeprom_page0_select;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] v;
    logic [7:0] w;
    logic [RAM_BYTES-1:0][7:0] ram;
    logic [PAGE_BYTES-1:0][7:0] page2;
    logic [7:0] rdata;
    logic [7:0] ext_data;
    logic ext_valid;
  } dsw_state_type;
endpackage

/* dsw_data_space.sv */
// Data space decoder: banked region, program memory window, index registers,
// direct RAM, window base and bank select, plus program counter and return stack.
// Assumes program memory answers combinationally within the access cycle.
//
// Behaviour
// R1: Program counter is twelve bits wide.
// R2: Return stack holds six twelve-bit return addresses.
// R3: Addresses 40h..7Fh read program memory bytes, not RAM.
// R4: Window moves in 64-byte steps per last written base value.
// R5: Window address is base bits above the six low address bits.
// R6: Window reaches every aligned 64-byte block of 000h..FFFh.
// R7: Window base at C9h takes plain byte writes; reads are meaningless.
// R8: Only base bits 5..0 are kept; bits 7 and 6 ignored.
// R9: Window base is not reset; software writes it first.
// R10: Addresses 00h..3Fh map to the selected RAM or EEPROM bank.
// R11: Index X, Y and short direct V, W sit at 80h..83h.
// R12: Sixty direct RAM bytes at 84h..BFh, independent of bank.
// R13: Readout protection blocks external program memory reads.
// R14: Program memory holds code and constants read through the window.
// R15: Bank select at E8h: bit 4 RAM page 2, bits 1/0 EEPROM pages.
// R16: Bank select is not reset; software writes it, one bit set.
// R17: Writes to reserved addresses and the window have no effect.
// R18: Window reads take the same latency as RAM reads.
`timescale 1ns/100ps
module dsw_data_space
  import dsw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] core_addr_i,
  input wire logic core_rd_i,
  input wire logic core_wr_i,
  input wire logic [7:0] core_wdata_i,
  output logic [7:0] core_rdata_o,
  output logic [PC_W-1:0] pmem_addr_o,
  input wire logic [7:0] pmem_data_i,
  input wire logic pc_inc_i,
  input wire logic pc_jump_i,
  input wire logic pc_call_i,
  input wire logic pc_ret_i,
  input wire logic [PC_W-1:0] pc_target_i,
  output logic [PC_W-1:0] pc_o,
  output logic eep_cs_o,
  output logic eep_page1_o,
  input wire logic [7:0] eep_rdata_i,
  output logic [7:0] idx_x_o,
  output logic [7:0] idx_y_o,
  output logic [7:0] sd_v_o,
  output logic [7:0] sd_w_o,
  input wire logic readout_protect_i,
  input wire logic ext_rd_i,
  input wire logic [PC_W-1:0] ext_addr_i,
  output logic [7:0] ext_data_o,
  output logic ext_valid_o
);

  dsw_state_type st_r;
  dsw_state_type st_nxt;
  logic in_bank;
  logic in_win;
  logic in_ram;
  logic win_rd;
  logic [7:0] ram_off;
  logic [5:0] ram_idx;
  logic [5:0] low6;
  logic [2:0] sp_dec;
  logic [2:0] sp_inc;

  assign in_bank = core_addr_i <= BANK_HI; // R10
  assign in_win = core_addr_i >= WIN_LO && core_addr_i <= WIN_HI; // R3
  assign in_ram = core_addr_i >= RAM_LO && core_addr_i <= RAM_HI; // R12
  assign win_rd = core_rd_i && in_win;
  assign ram_off = core_addr_i - RAM_LO;
  assign ram_idx = ram_off[5:0];
  assign low6 = core_addr_i[5:0];
  assign sp_dec = (st_r.sp == SP_RESET) ? SP_LAST : st_r.sp - 3'h1;
  assign sp_inc = (st_r.sp == SP_LAST) ? SP_RESET : st_r.sp + 3'h1;

  // A core window read owns the program memory port; external readout is dropped.
  // The window address is combinational so no wait state is needed.
  always_comb
  begin
    if (win_rd)
    begin
      pmem_addr_o = {st_r.win_pos, low6}; // R5 R6 R14
    end
    else
    begin
      pmem_addr_o = ext_addr_i;
    end
  end

  // Only a read or write inside the banked region with an EEPROM page
  // selected reaches the EEPROM; RAM page 2 takes precedence if misused.
  assign eep_cs_o = in_bank && (core_rd_i || core_wr_i) && !st_r.ram_page2_select
    && (st_r.eeprom_page0_select || st_r.eeprom_page1_select);
  assign eep_page1_o = st_r.eeprom_page1_select;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ext_valid = 1'b0;

    // Return stack wraps after six entries, overwriting the oldest.
    if (pc_ret_i)
    begin
      st_nxt.pc = st_r.stk[sp_dec]; // R2
      st_nxt.sp = sp_dec;
    end
    else if (pc_call_i)
    begin
      st_nxt.stk[st_r.sp] = st_r.pc + 12'h001; // R2
      st_nxt.sp = sp_inc;
      st_nxt.pc = pc_target_i;
    end
    else if (pc_jump_i)
    begin
      st_nxt.pc = pc_target_i;
    end
    else if (pc_inc_i)
    begin
      st_nxt.pc = st_r.pc + 12'h001; // R1
    end

    if (core_wr_i)
    begin
      if (in_bank)
      begin
        if (st_r.ram_page2_select)
        begin
          st_nxt.page2[low6] = core_wdata_i; // R10
        end
      end
      else if (in_ram)
      begin
        st_nxt.ram[ram_idx] = core_wdata_i; // R12
      end
      else
      begin
        case (core_addr_i)
          IDX_X_ADDR: st_nxt.x = core_wdata_i; // R11
          IDX_Y_ADDR: st_nxt.y = core_wdata_i;
          SD_V_ADDR: st_nxt.v = core_wdata_i;
          SD_W_ADDR: st_nxt.w = core_wdata_i;
          WIN_BASE_ADDR: st_nxt.win_pos = core_wdata_i[WIN_POS_W-1:0]; // R4 R7 R8
          BANK_SEL_ADDR:
          begin
            st_nxt.ram_page2_select = core_wdata_i[RAM_PAGE2_BIT]; // R15
            st_nxt.eeprom_page1_select = core_wdata_i[EEP1_BIT];
            st_nxt.eeprom_page0_select = core_wdata_i[EEP0_BIT];
          end
          default: st_nxt.x = st_r.x; // R17
        endcase
      end
    end

    if (core_rd_i)
    begin
      if (in_bank)
      begin
        if (st_r.ram_page2_select)
        begin
          st_nxt.rdata = st_r.page2[low6];
        end
        else if (eep_cs_o)
        begin
          st_nxt.rdata = eep_rdata_i;
        end
        else
        begin
          st_nxt.rdata = UNMAPPED_READ;
        end
      end
      else if (in_win)
      begin
        st_nxt.rdata = pmem_data_i; // R3 R18
      end
      else if (in_ram)
      begin
        st_nxt.rdata = st_r.ram[ram_idx];
      end
      else
      begin
        case (core_addr_i)
          IDX_X_ADDR: st_nxt.rdata = st_r.x;
          IDX_Y_ADDR: st_nxt.rdata = st_r.y;
          SD_V_ADDR: st_nxt.rdata = st_r.v;
          SD_W_ADDR: st_nxt.rdata = st_r.w;
          default: st_nxt.rdata = UNMAPPED_READ; // R7 R17
        endcase
      end
    end

    if (ext_rd_i && !win_rd)
    begin
      st_nxt.ext_valid = 1'b1;
      st_nxt.ext_data = readout_protect_i ? PROTECTED_READ : pmem_data_i; // R13
    end
  end

  // Window base, bank select and memories are left unreset on purpose:
  // software must load them before use, as on the original part.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r.pc <= PC_RESET;
      st_r.sp <= SP_RESET;
      st_r.x <= DATA_RESET;
      st_r.y <= DATA_RESET;
      st_r.v <= DATA_RESET;
      st_r.w <= DATA_RESET;
      st_r.rdata <= DATA_RESET;
      st_r.ext_data <= DATA_RESET;
      st_r.ext_valid <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt; // R9 R16
    end
  end

  assign core_rdata_o = st_r.rdata;
  assign pc_o = st_r.pc;
  assign idx_x_o = st_r.x;
  assign idx_y_o = st_r.y;
  assign sd_v_o = st_r.v;
  assign sd_w_o = st_r.w;
  assign ext_data_o = st_r.ext_data;
  assign ext_valid_o = st_r.ext_valid;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_win_latency: assert property ( // R18
    win_rd |=> core_rdata_o == $past(pmem_data_i))
    else $error("Window read data not returned one cycle later.");

  a_win_base_use: assert property ( // R4
    (core_wr_i && core_addr_i == WIN_BASE_ADDR) ##1 win_rd
    |-> pmem_addr_o[11:6] == $past(core_wdata_i[5:0]))
    else $error("Window position does not follow written base.");

  a_win_low_bits: assert property ( // R5
    win_rd |-> pmem_addr_o[5:0] == core_addr_i[5:0])
    else $error("Window low address bits not taken from the core address.");

  a_win_nowrite: assert property ( // R17
    core_wr_i && in_win |=> $stable(st_r.ram) && $stable(st_r.x) && $stable(st_r.win_pos))
    else $error("Write to the window changed state.");

  a_pc_step: assert property ( // R1
    pc_inc_i && !pc_jump_i && !pc_call_i && !pc_ret_i |=> pc_o == $past(pc_o) + 12'h001)
    else $error("Program counter did not advance by one.");

  a_call_return: assert property ( // R2
    (pc_call_i && !pc_ret_i) ##1 pc_ret_i |=> pc_o == $past(pc_o, 2) + 12'h001)
    else $error("Return did not restore the address after the call.");

  a_idx_write: assert property ( // R11
    core_wr_i && core_addr_i == IDX_X_ADDR |=> idx_x_o == $past(core_wdata_i))
    else $error("Index X not written at its address.");

  a_ram_rw: assert property ( // R12
    (core_wr_i && in_ram) ##1 (core_rd_i && !core_wr_i && core_addr_i == $past(core_addr_i))
    |=> core_rdata_o == $past(core_wdata_i, 2))
    else $error("Direct RAM read did not return written byte.");

  a_bank_page2: assert property ( // R10
    (core_wr_i && core_addr_i == BANK_SEL_ADDR && core_wdata_i == 8'h10)
    ##1 (core_wr_i && in_bank) ##1 (core_rd_i && !core_wr_i
    && core_addr_i == $past(core_addr_i)) |=> core_rdata_o == $past(core_wdata_i, 2))
    else $error("RAM page 2 did not hold the written byte.");

  a_protect: assert property ( // R13
    ext_rd_i && !win_rd && readout_protect_i |=> ext_valid_o && ext_data_o == PROTECTED_READ)
    else $error("Protected program memory was read out.");

  // A window read must turn an external readout away outright, never stretch it.
  // The requester sees no valid pulse and has to ask again.
  a_ext_yield: assert property ( // R18
    ext_rd_i && win_rd |=> !ext_valid_o)
    else $error("External readout served during a core window read.");

  a_base_read: assert property ( // R7
    core_rd_i && core_addr_i == WIN_BASE_ADDR |=> core_rdata_o == UNMAPPED_READ)
    else $error("Window base read returned something other than the unmapped value.");

  a_eep_select: assert property ( // R15
    core_rd_i && in_bank && !st_r.ram_page2_select && st_r.eeprom_page1_select
    |-> eep_cs_o && eep_page1_o)
    else $error("EEPROM page 1 not selected for a banked access.");

  a_bank_empty: assert property ( // R10
    core_rd_i && in_bank && !st_r.ram_page2_select && !st_r.eeprom_page0_select
    && !st_r.eeprom_page1_select |=> core_rdata_o == UNMAPPED_READ)
    else $error("Banked read with no bank selected returned stale data.");

  a_sp_wrap: assert property ( // R2
    pc_call_i && !pc_ret_i && st_r.sp == SP_LAST |=> st_r.sp == SP_RESET)
    else $error("Return stack pointer did not wrap after six entries.");

  c_win_read: cover property (core_wr_i && core_addr_i == WIN_BASE_ADDR ##1 win_rd);
  c_call_ret: cover property (pc_call_i ##[1:4] pc_ret_i);
  c_ext_read: cover property (ext_rd_i && !readout_protect_i && !win_rd);
  c_eep_page1: cover property (eep_cs_o && eep_page1_o);
  c_ram_b2b: cover property (core_wr_i && in_ram ##1 core_rd_i && in_ram);

endmodule

/* dsw_pmem_model.sv */
// Program memory and EEPROM model standing beside the data space decoder.
// Both answer combinationally in the cycle of the address, as the core bus expects.
`timescale 1ns/100ps
module dsw_pmem_model
  import dsw_pkg::*;
(
  input wire logic [PC_W-1:0] pmem_addr_i,
  input wire logic eep_cs_i,
  input wire logic eep_page1_i,
  output logic [7:0] pmem_data_o,
  output logic [7:0] eep_rdata_o
);
  // Bytes depend on every address bit, so a wrong window base reads a wrong value.
  assign pmem_data_o = pmem_addr_i[7:0] ^ pmem_addr_i[11:4];
  // A deselected EEPROM shows a changing value rather than a stale byte.
  assign eep_rdata_o = eep_cs_i ? {7'h61, eep_page1_i} : ~pmem_addr_i[7:0];
endmodule

/* tb_top.sv */
// Self-checking bench for the data space decoder and program counter.
// Assumes the program memory model answers in the cycle of the address.
`timescale 1ns/100ps
module tb_top;
  import dsw_pkg::*;
  logic mclk_i, rst_i, rd, wr, inc, jmp, call, ret, prot, xrd, eep_cs, eep_p1, xval;
  logic [7:0] addr, wdata, rdata, eep_rd, pdata, ix, iy, sv, sw, xdata;
  logic [11:0] tgt, pma, pc, xaddr;
  int err_total, total_checks;
  dsw_data_space DUT (.mclk_i(mclk_i), .rst_i(rst_i), .core_addr_i(addr), .core_rd_i(rd),
    .core_wr_i(wr), .core_wdata_i(wdata), .core_rdata_o(rdata), .pmem_addr_o(pma),
    .pmem_data_i(pdata), .pc_inc_i(inc), .pc_jump_i(jmp), .pc_call_i(call), .pc_ret_i(ret),
    .pc_target_i(tgt), .pc_o(pc), .eep_cs_o(eep_cs), .eep_page1_o(eep_p1),
    .eep_rdata_i(eep_rd), .idx_x_o(ix), .idx_y_o(iy), .sd_v_o(sv), .sd_w_o(sw),
    .readout_protect_i(prot), .ext_rd_i(xrd), .ext_addr_i(xaddr), .ext_data_o(xdata),
    .ext_valid_o(xval));
  dsw_pmem_model pmem (.pmem_addr_i(pma), .eep_cs_i(eep_cs), .eep_page1_i(eep_p1),
    .pmem_data_o(pdata), .eep_rdata_o(eep_rd));
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  function automatic logic [7:0] pm(input logic [11:0] a);
    return a[7:0] ^ a[11:4];
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge mclk_i);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd_b(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge mclk_i);
    #1;
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  task automatic pcc(input logic [3:0] c, input logic [11:0] t);
    @(posedge mclk_i);
    #1;
    {ret, call, jmp, inc} = c;
    tgt = t;
    @(posedge mclk_i);
    #1;
    {ret, call, jmp, inc} = 4'h0;
  endtask
  task automatic t_pc;
    chk({pc, rdata, ix, sw, xval}, {PC_RESET, DATA_RESET, DATA_RESET, DATA_RESET, 1'b0});
    pcc(4'h2, 12'hFFF);
    chk(pc, 12'hFFF);
    pcc(4'h1, 12'h000);
    chk(pc, 12'h000);
    pcc(4'h3, 12'h100);
    chk(pc, 12'h100);
    pcc(4'h4, 12'h300);
    pcc(4'hC, 12'h500);
    chk(pc, 12'h101);
    for (int i = 0; i < 6; i++)
      pcc(4'h4, 12'(12'h200 + 16 * i));
    for (int i = 5; i >= 0; i--)
    begin
      pcc(4'h8, 12'h000);
      chk(pc, (i == 0) ? 12'h102 : 12'(12'h1F1 + 16 * i));
    end
    $display("pc test done");
  endtask
  task automatic t_window;
    logic [7:0] b [3] = '{8'h00, 8'h03, 8'hFF};
    foreach (b[i])
    begin
      wr_b(WIN_BASE_ADDR, b[i]);
      rd_b(WIN_LO, pm({b[i][5:0], 6'h00}));
      rd_b(WIN_HI, pm({b[i][5:0], 6'h3F}));
    end
    wr_b(8'h45, 8'hAA);
    rd_b(8'h45, pm(12'hFC5));
    rd_b(WIN_BASE_ADDR, UNMAPPED_READ);
    $display("window test done");
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
      wr_b(8'(8'h80 + i), 8'(8'h11 * (i + 1)));
    chk({ix, iy, sv, sw}, 32'h11223344);
    rd_b(SD_W_ADDR, 8'h44);
    wr_b(RAM_LO, 8'h5A);
    wr_b(RAM_HI, 8'hA5);
    rd_b(RAM_HI, 8'hA5);
    wr_b(8'hC3, 8'h12);
    rd_b(8'hC3, UNMAPPED_READ);
    $display("register test done");
  endtask
  task automatic t_bank;
    wr_b(BANK_SEL_ADDR, 8'h10);
    wr_b(8'h00, 8'h77);
    wr_b(BANK_HI, 8'h88);
    rd_b(8'h00, 8'h77);
    rd_b(BANK_HI, 8'h88);
    wr_b(BANK_SEL_ADDR, 8'h01);
    chk(eep_p1, 1'b0);
    rd_b(8'h05, 8'hC2);
    wr_b(BANK_SEL_ADDR, 8'h02);
    chk(eep_p1, 1'b1);
    rd_b(8'h05, 8'hC3);
    wr_b(BANK_SEL_ADDR, 8'h00);
    rd_b(8'h05, UNMAPPED_READ);
    rd_b(RAM_LO, 8'h5A);
    wr_b(BANK_SEL_ADDR, 8'h10);
    rd_b(8'h00, 8'h77);
    $display("bank test done");
  endtask
  task automatic bus(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    rd = r;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge mclk_i);
    #1;
  endtask
  // Accesses here fall on consecutive edges, so no idle cycle hides a stale value.
  task automatic t_b2b;
    @(posedge mclk_i);
    #1;
    bus(1'b0, 1'b1, WIN_BASE_ADDR, 8'hC5);
    bus(1'b1, 1'b0, 8'h4A, 8'h00);
    chk(pma, 12'h14A);
    chk(rdata, pm(12'h14A));
    bus(1'b0, 1'b1, 8'h90, 8'h3C);
    bus(1'b1, 1'b0, 8'h90, 8'h00);
    chk(rdata, 8'h3C);
    bus(1'b1, 1'b1, 8'h90, 8'hC3);
    chk(rdata, 8'h3C);
    bus(1'b1, 1'b0, 8'h90, 8'h00);
    chk(rdata, 8'hC3);
    bus(1'b0, 1'b1, BANK_SEL_ADDR, 8'h10);
    bus(1'b0, 1'b1, 8'h20, 8'h66);
    bus(1'b1, 1'b0, 8'h20, 8'h00);
    chk(rdata, 8'h66);
    rd = 1'b0;
    jmp = 1'b1;
    tgt = 12'h0F0;
    @(posedge mclk_i);
    #1;
    jmp = 1'b0;
    call = 1'b1;
    tgt = 12'h3A0;
    chk(pc, 12'h0F0);
    @(posedge mclk_i);
    #1;
    call = 1'b0;
    ret = 1'b1;
    chk(pc, 12'h3A0);
    @(posedge mclk_i);
    #1;
    ret = 1'b0;
    chk(pc, 12'h0F1);
    $display("back to back test done");
  endtask
  task automatic t_ext;
    for (int p = 0; p < 3; p++)
    begin
      @(posedge mclk_i);
      #1;
      prot = p[0];
      xaddr = 12'hABC;
      xrd = 1'b1;
      addr = WIN_LO;
      // The last pass collides with a core window read, which takes the port.
      rd = (p == 2);
      @(posedge mclk_i);
      #1;
      xrd = 1'b0;
      rd = 1'b0;
      chk(xval, p < 2);
      if (p < 2)
        chk(xdata, p ? PROTECTED_READ : pm(12'hABC));
      else
      begin
        chk(xdata, PROTECTED_READ);
        chk(rdata, pm(12'h140));
      end
    end
    $display("readout test done");
  endtask
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {rst_i, rd, wr, inc, jmp, call, ret, prot, xrd} = 9'h100;
    {addr, wdata, tgt, xaddr} = 40'h0;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    t_pc;
    t_window;
    t_regs;
    t_bank;
    t_b2b;
    t_ext;
    tally_and_finish;
  end
endmodule
